// [ism_source_mask.sv]
`timescale 1ns/100ps

// Operation
// - Enable bit 0 blocks its event from the interrupt; bit 1 lets it through.
// - Low enable byte bits 0..7 serve ref_in_1 through ref_in_8.
// - Middle enable byte is software read/write; bits 0..4 serve ref_in_9..13.
// - Middle byte bit 5 gates ref_in_14.
// - Middle bit 6 gates main reference failure, bit 7 operating mode change.
// - Low byte is read/write; both bytes reset to zero, all sources masked.
module ism_source_mask
    import ism_pkg::*;
#(
    parameter int NUM_MASK_BYTES = MASK_BYTES
)
(
    // Clock, reset, enable
    input  wire logic              clk,
    input  wire logic              arst_n,
    input  wire logic              ce,
    // Register port
    input  wire ism_req_s          regReq,
    output logic      [DATA_W-1:0] rdData,
    // Event flags from the status logic
    input  wire ism_evt_s          eventFlag,
    // Interrupt request
    output logic                   irqReq
);

    // ==========================================================
    // Elaboration check
    generate
        if (NUM_MASK_BYTES * DATA_W != $bits(ism_evt_s)) begin : g_bad_width
            $error("enable bytes must cover every event flag exactly");
        end
    endgenerate

    // ==========================================================
    // Internal signals
    localparam int NSRC = NUM_MASK_BYTES * DATA_W;

    logic [NSRC-1:0]   enable;
    logic [NSRC-1:0]   pending;
    logic [NSRC-1:0]   flagVec;
    logic              hitEnLow;
    logic              hitEnMid;
    logic              hitPendLow;
    logic              hitPendMid;
    logic              next_irqReq;
    logic [DATA_W-1:0] next_rdData;

    // ==========================================================
    // Address decode
    assign hitEnLow   = regReq.addr == OFF_EN_LOW;
    assign hitEnMid   = regReq.addr == OFF_EN_MID;
    assign hitPendLow = regReq.addr == OFF_PEND_LOW;
    assign hitPendMid = regReq.addr == OFF_PEND_MID;

    // ==========================================================
    // Enable bytes, one register per byte, consecutive offsets
    generate
        for (genvar b = 0; b < NUM_MASK_BYTES; b++) begin : g_en
            localparam logic [7:0] BYTE_OFF = OFF_EN_LOW + 8'(b);
            logic we;

            // Writes are frozen with the clock enable
            assign we = ce & regReq.wr & (regReq.addr == BYTE_OFF);

            ism_byte_reg #(
                .RESET_VAL (EN_RESET)
            ) u_byte (
                .clk    (clk),
                .arst_n (arst_n),
                .we     (we),
                .d      (regReq.wrData),
                .q      (enable[DATA_W*b +: DATA_W])
            );
        end
    endgenerate

    // ==========================================================
    // Gating and request
    // Flags come from same-clock status logic, so no synchroniser
    assign flagVec     = eventFlag;
    assign pending     = flagVec & enable;
    assign next_irqReq = |pending;

    // ==========================================================
    // Read selection
    // Pending view lets software see which gated source fired
    assign next_rdData = !regReq.rd ? READ_ZERO          :
                         hitEnLow   ? enable[7:0]        :
                         hitEnMid   ? enable[15:8]       :
                         hitPendLow ? pending[7:0]       :
                         hitPendMid ? pending[15:8]      :
                                      READ_ZERO;

    // ==========================================================
    // Output flops
    // Read data is cleared in every non-read cycle with ce high, so it stands for one enabled cycle only
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irqReq <= 1'b0;
            rdData <= READ_ZERO;
        end else if (ce) begin
            irqReq <= next_irqReq;
            rdData <= next_rdData;
        end
    end

    // ==========================================================
    // Assertions: register access
    a_low_write_stores: assert property (@(posedge clk) disable iff (!arst_n)
        ce && regReq.wr && hitEnLow |=> enable[7:0] == $past(regReq.wrData))
        else $error("low enable byte did not take the written value");

    a_mid_write_stores: assert property (@(posedge clk) disable iff (!arst_n)
        ce && regReq.wr && hitEnMid |=> enable[15:8] == $past(regReq.wrData))
        else $error("middle enable byte did not take the written value");

    a_low_read_back: assert property (@(posedge clk) disable iff (!arst_n)
        ce && regReq.rd && hitEnLow |=> rdData == $past(enable[7:0]))
        else $error("low enable byte read back wrong");

    a_mid_read_back: assert property (@(posedge clk) disable iff (!arst_n)
        ce && regReq.rd && hitEnMid |=> rdData == $past(enable[15:8]))
        else $error("middle enable byte read back wrong");

    a_frozen_no_write: assert property (@(posedge clk) disable iff (!arst_n)
        !ce |=> enable == $past(enable) && irqReq == $past(irqReq))
        else $error("state moved while the clock enable was low");

    a_reset_all_masked: assert property (@(posedge clk)
        !$past(arst_n) && arst_n |-> enable == ALL_MASKED && !irqReq)
        else $error("enable bytes not zero after reset");

    // ==========================================================
    // Assertions: gating
    a_masked_stays_low: assert property (@(posedge clk) disable iff (!arst_n)
        ce && (flagVec & enable) == ALL_MASKED |=> !irqReq)
        else $error("request raised with every set flag masked");

    a_any_unmasked_high: assert property (@(posedge clk) disable iff (!arst_n)
        ce && |(flagVec & enable) |=> irqReq)
        else $error("request missing for an unmasked flag");

    a_low_bit_order: assert property (@(posedge clk) disable iff (!arst_n)
        ce && flagVec == NSRC'(1) << POS_REF_IN_8 && enable[POS_REF_IN_8]
        ##1 ce && flagVec == NSRC'(1) << POS_REF_IN_8 |=> irqReq)
        else $error("ref_in_8 not gated by low byte bit 7");

    a_ref14_gate: assert property (@(posedge clk) disable iff (!arst_n)
        ce && eventFlag.refIn[POS_REF_IN_14] && !enable[POS_REF_IN_14]
        && (flagVec & enable) == ALL_MASKED |=> !irqReq)
        else $error("ref_in_14 raised a request while masked");

    a_main_fail_gate: assert property (@(posedge clk) disable iff (!arst_n)
        ce && eventFlag.mainRefFail && enable[POS_MAIN_FAIL] |=> irqReq)
        else $error("main reference failure did not raise the request");

    a_mode_chg_gate: assert property (@(posedge clk) disable iff (!arst_n)
        ce && eventFlag.modeChange && enable[POS_MODE_CHG] |=> irqReq)
        else $error("mode change did not raise the request");

    a_mid_ref_order: assert property (@(posedge clk) disable iff (!arst_n)
        ce && eventFlag.refIn[POS_REF_IN_9] && enable[POS_REF_IN_9] |=> irqReq)
        else $error("ref_in_9 not gated by middle byte bit 0");

    a_read_one_cycle: assert property (@(posedge clk) disable iff (!arst_n)
        ce && !regReq.rd |=> rdData == READ_ZERO)
        else $error("read data standing outside its cycle");

    // ==========================================================
    // Assertions: pending view and unmapped space
    // The pending bytes are a read-only view; a stray write there
    // must never leak into the enable bytes sharing the port
    a_pend_low_read: assert property (@(posedge clk) disable iff (!arst_n)
        ce && regReq.rd && hitPendLow |=> rdData == $past(pending[7:0]))
        else $error("low pending byte read back wrong");

    a_pend_mid_read: assert property (@(posedge clk) disable iff (!arst_n)
        ce && regReq.rd && hitPendMid |=> rdData == $past(pending[15:8]))
        else $error("middle pending byte read back wrong");

    a_pend_no_write: assert property (@(posedge clk) disable iff (!arst_n)
        ce && regReq.wr && (hitPendLow || hitPendMid) |=> enable == $past(enable))
        else $error("write to pending view changed the enables");

    a_unmapped_zero: assert property (@(posedge clk) disable iff (!arst_n)
        ce && regReq.rd && !(hitEnLow || hitEnMid || hitPendLow || hitPendMid)
        |=> rdData == READ_ZERO)
        else $error("unmapped read returned nonzero data");

    a_low_write_alone: assert property (@(posedge clk) disable iff (!arst_n)
        ce && regReq.wr && hitEnLow |=> enable[15:8] == $past(enable[15:8]))
        else $error("low byte write disturbed the middle byte");

    a_mid_write_alone: assert property (@(posedge clk) disable iff (!arst_n)
        ce && regReq.wr && hitEnMid |=> enable[7:0] == $past(enable[7:0]))
        else $error("middle byte write disturbed the low byte");

    // Only a decoded write may move an enable bit; reads have no side effect
    a_enable_by_write: assert property (@(posedge clk) disable iff (!arst_n)
        ce && !(regReq.wr && (hitEnLow || hitEnMid)) |=> enable == $past(enable))
        else $error("enable bytes moved without a write");

    a_frozen_write: assert property (@(posedge clk) disable iff (!arst_n)
        !ce && regReq.wr |=> enable == $past(enable))
        else $error("write taken while the clock enable was low");

    // ==========================================================
    // Assertions: read path and request timing
    a_frozen_read: assert property (@(posedge clk) disable iff (!arst_n)
        !ce |=> rdData == $past(rdData))
        else $error("read data moved while the clock enable was low");

    a_reset_read_zero: assert property (@(posedge clk)
        !$past(arst_n) && arst_n |-> rdData == READ_ZERO)
        else $error("read data not zero after reset");

    // Fixed one-cycle latency; software polling relies on it
    a_irq_latency: assert property (@(posedge clk) disable iff (!arst_n)
        ce |=> irqReq == $past(|pending))
        else $error("request does not follow the gated flags");

    a_irq_drops: assert property (@(posedge clk) disable iff (!arst_n)
        ce && irqReq && (flagVec & enable) == ALL_MASKED |=> !irqReq)
        else $error("request held with no unmasked flag");

    a_mode_chg_masked: assert property (@(posedge clk) disable iff (!arst_n)
        ce && flagVec == NSRC'(1) << POS_MODE_CHG && !enable[POS_MODE_CHG] |=> !irqReq)
        else $error("masked mode change raised the request");

    a_main_fail_masked: assert property (@(posedge clk) disable iff (!arst_n)
        ce && flagVec == NSRC'(1) << POS_MAIN_FAIL && !enable[POS_MAIN_FAIL] |=> !irqReq)
        else $error("masked main reference failure raised the request");

    // ==========================================================
    // Assertions: per byte and per bit
    // One instance per byte and per source keeps the bit order honest
    generate
        for (genvar b = 0; b < NUM_MASK_BYTES; b++) begin : g_byte_chk
            localparam logic [7:0] CHK_OFF = OFF_EN_LOW + 8'(b);

            a_byte_read: assert property (@(posedge clk) disable iff (!arst_n)
                ce && regReq.rd && regReq.addr == CHK_OFF
                |=> rdData == $past(enable[DATA_W*b +: DATA_W]))
                else $error("enable byte read back from the wrong place");
        end

        for (genvar i = 0; i < NSRC; i++) begin : g_bit_chk
            a_bit_blocks: assert property (@(posedge clk) disable iff (!arst_n)
                ce && flagVec == NSRC'(1) << i && !enable[i] |=> !irqReq)
                else $error("masked source raised the request");

            a_bit_passes: assert property (@(posedge clk) disable iff (!arst_n)
                ce && flagVec[i] && enable[i] |=> irqReq)
                else $error("enabled source did not raise the request");
        end
    endgenerate

    // ==========================================================
    // Coverage
    c_enable_then_irq: cover property (@(posedge clk) disable iff (!arst_n)
        ce && regReq.wr && hitEnMid ##1 ce && eventFlag.modeChange ##1 irqReq);

    c_irq_falls: cover property (@(posedge clk) disable iff (!arst_n)
        irqReq ##1 !irqReq);

    c_pending_read: cover property (@(posedge clk) disable iff (!arst_n)
        ce && regReq.rd && hitPendLow && pending[POS_REF_IN_1]);

    c_masked_flag: cover property (@(posedge clk) disable iff (!arst_n)
        ce && flagVec != ALL_MASKED && pending == ALL_MASKED);

    c_ce_frozen: cover property (@(posedge clk) disable iff (!arst_n)
        !ce && irqReq ##1 !ce && irqReq);

endmodule

// [ism_pkg.sv]
package ism_pkg;

    // ==========================================================
    // Register port geometry
    localparam int          ADDR_W        = 8;
    localparam int          DATA_W        = 8;
    localparam int          MASK_BYTES    = 2;

    // ==========================================================
    // Register offsets
    localparam logic [7:0]  OFF_EN_LOW    = 8'h43;
    localparam logic [7:0]  OFF_EN_MID    = 8'h44;
    localparam logic [7:0]  OFF_PEND_LOW  = 8'h50;
    localparam logic [7:0]  OFF_PEND_MID  = 8'h51;

    // ==========================================================
    // Reset and read values
    localparam logic [7:0]  EN_RESET      = 8'h00;
    localparam logic [7:0]  READ_ZERO     = 8'h00;
    localparam logic [15:0] ALL_MASKED    = 16'h0000;

    // ==========================================================
    // Source positions in the 16-bit enable word
    localparam int          NUM_REF_IN    = 14;
    localparam int          POS_REF_IN_1  = 0;
    localparam int          POS_REF_IN_8  = 7;
    localparam int          POS_REF_IN_9  = 8;
    localparam int          POS_REF_IN_14 = 13;
    localparam int          POS_MAIN_FAIL = 14;
    localparam int          POS_MODE_CHG  = 15;

    // ==========================================================
    // Carriers
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wrData;
        logic              wr;
        logic              rd;
    } ism_req_s;

    // Bit order matches the enable word: refIn[0] is ref_in_1
    typedef struct packed {
        logic                  modeChange;
        logic                  mainRefFail;
        logic [NUM_REF_IN-1:0] refIn;
    } ism_evt_s;

endpackage

// [ism_byte_reg.sv]
`timescale 1ns/100ps

module ism_byte_reg
    import ism_pkg::*;
#(
    parameter logic [DATA_W-1:0] RESET_VAL = EN_RESET
)
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              arst_n,
    // Write side
    input  wire logic              we,
    input  wire logic [DATA_W-1:0] d,
    // Stored value
    output logic      [DATA_W-1:0] q
);

    // ==========================================================
    // Storage
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= RESET_VAL;
        end else if (we) begin
            q <= d;
        end
    end

    // ==========================================================
    // Checks
    a_byte_hold: assert property (@(posedge clk) disable iff (!arst_n)
        !we |=> q == $past(q))
        else $error("enable byte changed without a write");

endmodule

// [test_ism_source_mask.sv]
`timescale 1ns/100ps

module test_ism_source_mask;
    import ism_pkg::*;

    // ==========================================================
    // Wiring
    typedef struct {
        logic [7:0]  lo;
        logic [7:0]  mid;
        logic [15:0] evt;
        logic        irq;
    } ism_row_s;

    logic              clk       = 1'b0;
    logic              arst_n    = 1'b0;
    logic              ce        = 1'b1;
    ism_req_s          regReq    = '0;
    ism_evt_s          eventFlag = '0;
    logic [DATA_W-1:0] rdData;
    logic              irqReq;
    logic [7:0]        seen;
    int                failures  = 0;
    int                checks    = 0;
    int                cycles    = 0;

    // Boundary bits of each byte, plus fully masked cases
    ism_row_s rows [10] = '{
        '{8'h01, 8'h00, 16'h0001, 1'b1}, '{8'h80, 8'h00, 16'h0080, 1'b1},
        '{8'h7F, 8'h00, 16'h0080, 1'b0}, '{8'h00, 8'h01, 16'h0100, 1'b1},
        '{8'h00, 8'h10, 16'h1000, 1'b1}, '{8'h00, 8'h20, 16'h2000, 1'b1},
        '{8'h00, 8'h40, 16'h4000, 1'b1}, '{8'h00, 8'h80, 16'h8000, 1'b1},
        '{8'hFF, 8'h7F, 16'h8000, 1'b0}, '{8'h00, 8'h00, 16'hFFFF, 1'b0}};

    ism_source_mask u_dut (
        .clk       (clk),
        .arst_n    (arst_n),
        .ce        (ce),
        .regReq    (regReq),
        .rdData    (rdData),
        .eventFlag (eventFlag),
        .irqReq    (irqReq)
    );

    always #10 clk = ~clk;

    // ==========================================================
    // Checking and bus tasks
    task automatic close_out();
        $display("checks=%0d failures=%0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_irq(input logic e);
        checks++;
        if (irqReq !== e) begin
            failures++;
            $display("MISMATCH irqReq expected %b seen %b", e, irqReq);
        end
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regReq <= '{addr: a, wrData: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        regReq <= '0;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk);
        regReq <= '{addr: a, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        regReq <= '0;
        #1 seen = rdData;
    endtask

    // One cycle of request latency
    task automatic set_evt(input logic [15:0] v);
        @(posedge clk);
        eventFlag <= v;
        @(posedge clk);
        #1;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 1500) begin
            failures++;
            close_out();
        end
    end

    // ==========================================================
    // Sequence
    initial begin
        repeat (12) @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        set_evt(16'hFFFF);
        chk_irq(1'b0);
        rd_reg(OFF_EN_LOW);
        chk_byte("enLow", 8'h00, seen);
        rd_reg(OFF_EN_MID);
        chk_byte("enMid", 8'h00, seen);
        set_evt(16'h0000);
        $display("reset test done");
        foreach (rows[i]) begin
            wr_reg(OFF_EN_LOW, rows[i].lo);
            wr_reg(OFF_EN_MID, rows[i].mid);
            rd_reg(OFF_EN_LOW);
            chk_byte("enLow", rows[i].lo, seen);
            rd_reg(OFF_EN_MID);
            chk_byte("enMid", rows[i].mid, seen);
            set_evt(rows[i].evt);
            chk_irq(rows[i].irq);
            set_evt(16'h0000);
            chk_irq(1'b0);
        end
        $display("table test done");
        // Back-to-back write then read, then data must fall away
        @(posedge clk);
        regReq <= '{addr: OFF_EN_MID, wrData: 8'hA5, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        regReq <= '{addr: OFF_EN_MID, wrData: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        regReq <= '0;
        #1 chk_byte("rdData", 8'hA5, rdData);
        @(posedge clk);
        #1 chk_byte("rdData", 8'h00, rdData);
        wr_reg(8'h45, 8'hFF);
        rd_reg(8'h45);
        chk_byte("unmapped", 8'h00, seen);
        rd_reg(OFF_EN_MID);
        chk_byte("enMid", 8'hA5, seen);
        $display("access test done");
        // Pending view, ignored write to it, then a frozen clock enable
        wr_reg(OFF_EN_LOW, 8'h01);
        set_evt(16'h0101);
        rd_reg(OFF_PEND_LOW);
        chk_byte("pendLow", 8'h01, seen);
        rd_reg(OFF_PEND_MID);
        chk_byte("pendMid", 8'h01, seen);
        wr_reg(OFF_PEND_LOW, 8'h00);
        rd_reg(OFF_EN_LOW);
        chk_byte("enLow", 8'h01, seen);
        @(posedge clk);
        ce <= 1'b0;
        eventFlag <= '0;
        regReq <= '{addr: OFF_EN_LOW, wrData: 8'h00, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        regReq <= '0;
        @(posedge clk);
        #1 chk_irq(1'b1);
        @(posedge clk);
        ce <= 1'b1;
        set_evt(16'h0000);
        chk_irq(1'b0);
        rd_reg(OFF_EN_LOW);
        chk_byte("enLow", 8'h01, seen);
        $display("pending and freeze test done");
        // Mid-run reset must mask every source again
        wr_reg(OFF_EN_LOW, 8'hFF);
        set_evt(16'h0001);
        chk_irq(1'b1);
        @(posedge clk);
        arst_n <= 1'b0;
        #1 chk_irq(1'b0);
        @(posedge clk);
        arst_n <= 1'b1;
        set_evt(16'hFFFF);
        chk_irq(1'b0);
        rd_reg(OFF_EN_LOW);
        chk_byte("enLow", 8'h00, seen);
        $display("reset again test done");
        close_out();
    end

endmodule
